// ==== hdl/lsp_led_status.sv ====
`timescale 1ns/1ps
// Operation
// - each pin selects open-drain active-low or totem-pole active-high drive
// - reset gives open-drain, stretch on; link_indicator_pin link, receive_indicator_pin receive, transmit_indicator_pin transmit
// - each source ANDed with its enable, all ORed into combined status
// - combined status either feeds the stretcher or bypasses it
// - stretcher is a three-bit shift register advanced by a slow tick
// - stretcher serial input is held at zero
// - asserted combined status sets all three stretcher bits at once
// - with stretching, an open-drain pin follows inverted stretcher output, a totem-pole pin follows it uninverted
// - stretched indication lasts two to three ticks
module lsp_led_status #(
    parameter int NUM_SRC      = lsp_pkg::LSP_NUM_SRC,
    parameter int TICK_CYCLES  = lsp_pkg::LSP_TICK_CYCLES
) (
    input  wire logic                                clock,          // device clock
    input  wire logic                                resetn,         // sync reset, active low
    input  wire logic [lsp_pkg::LSP_NUM_SRC-1:0]     status_src,     // shared status sources
    input  wire logic                                cfg_load,       // load cfg_in this cycle
    input  wire lsp_pkg::lsp_cfg_t                   cfg_in,         // new configuration
    output lsp_pkg::lsp_cfg_t                        cfg_out,        // current configuration
    output logic                                     link_indicator_pin_level,     // link_indicator_pin level
    output logic                                     link_indicator_pin_oe,        // link_indicator_pin enable
    output logic                                     receive_indicator_pin_level,  // receive_indicator_pin level
    output logic                                     receive_indicator_pin_oe,     // receive_indicator_pin enable
    output logic                                     third_indicator_pin_level,    // third_indicator_pin level
    output logic                                     third_indicator_pin_oe,       // third_indicator_pin enable
    output logic                                     transmit_indicator_pin_level, // transmit_indicator_pin level
    output logic                                     transmit_indicator_pin_oe     // transmit_indicator_pin enable
);
    import lsp_pkg::*;

    // ****************************************
    // local constants
    // ****************************************
    // top stretcher bit; the pin only ever looks at this one
    localparam int                          STR_MSB       = LSP_STRETCH_BITS - 1;
    // all stretcher bits set, the reload value on an event
    localparam logic [LSP_STRETCH_BITS-1:0] STR_FULL      = '1;
    // serial input of every stretcher, tied low
    localparam logic                        STR_SERIAL_IN = 1'b0;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        lsp_cfg_t                                     cfg;
        logic [LSP_NUM_LEDS-1:0][LSP_STRETCH_BITS-1:0] shreg;
        lsp_pins_t                                    pins;
    } lsp_state_t;

    lsp_state_t st_q;
    lsp_state_t st_d;
    logic       tick;
    logic [LSP_NUM_LEDS-1:0] combined;
    logic [LSP_NUM_LEDS-1:0] active;

    // ****************************************
    // slow tick
    // ****************************************
    // one tick for all four stretchers keeps their phases equal
    lsp_tick_gen #(
        .PERIOD (TICK_CYCLES)
    ) u_tick (
        .clock  (clock),
        .resetn (resetn),
        .tick   (tick)          // about 38 Hz
    );

    // ****************************************
    // pin drive decode
    // ****************************************
    // decode one pin: level and enable for a given drive mode
    function automatic logic [1:0] pin_drive(
        input logic totem,  // 1 totem pole, 0 open drain
        input logic on      // led should glow
    );
        // open drain only pulls low when lit, floats otherwise
        if (totem) begin
            pin_drive = {on, 1'b1};
        end else begin
            pin_drive = {1'b0, on};
        end
    endfunction

    // ****************************************
    // stretcher step
    // ****************************************
    // next stretcher word for one led
    function automatic logic [LSP_STRETCH_BITS-1:0] stretch_next(
        input logic [LSP_STRETCH_BITS-1:0] cur,  // current word
        input logic                        set,  // combined status
        input logic                        adv   // slow tick
    );
        // set in the same cycle as a tick wins, so a short event is never lost
        if (set) begin
            stretch_next = STR_FULL;
        end else if (adv) begin
            // shift toward the msb, zero enters at the bottom
            stretch_next = {cur[STR_MSB-1:0], STR_SERIAL_IN};
        end else begin
            stretch_next = cur;
        end
    endfunction

    // level the led should show, before the drive mode is applied
    function automatic logic glow_level(
        input logic                        stretched,  // stretcher in path
        input logic [LSP_STRETCH_BITS-1:0] word,       // current stretcher word
        input logic                        comb        // combined status
    );
        // inverted msb drives an active-low pin, so lit equals msb
        if (stretched) begin
            glow_level = word[STR_MSB];
        end else begin
            glow_level = comb;
        end
    endfunction

    // ****************************************
    // source gating
    // ****************************************
    // true when any enabled source is asserted
    function automatic logic any_enabled(
        input logic [LSP_NUM_SRC-1:0] src,  // status sources
        input logic [LSP_NUM_SRC-1:0] en    // per-source enables
    );
        any_enabled = |(src & en);
    endfunction

    // gated sources ORed per led
    generate
        for (genvar i = 0; i < LSP_NUM_LEDS; i++) begin : g_comb
            assign combined[i] = any_enabled(status_src, st_q.cfg.enable[i]);
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [1:0] drv;
        drv = 2'b00;
        st_d = st_q;
        active = '0;
        if (cfg_load) begin
            st_d.cfg = cfg_in;
        end
        for (int i = 0; i < LSP_NUM_LEDS; i++) begin
            // set dominates shifting; lit for 2..3 ticks after event
            st_d.shreg[i] = stretch_next(st_q.shreg[i], combined[i], tick);
            // stretched path shows the msb, bypass the live status
            active[i] = glow_level(st_q.cfg.stretch[i], st_q.shreg[i],
                                   combined[i]);
            // drive mode only changes polarity and enable, not timing
            drv = pin_drive(st_q.cfg.totem[i], active[i]);
            st_d.pins.out[i] = drv[1];
            st_d.pins.oe[i]  = drv[0];
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // sync reset loads the default configuration
    // stretchers and pins clear so every led starts dark
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q.cfg.enable  <= {LSP_RST_EN3, LSP_RST_EN2, LSP_RST_EN1, LSP_RST_EN0};
            st_q.cfg.totem   <= LSP_RST_TOTEM;
            st_q.cfg.stretch <= LSP_RST_STRETCH;
            st_q.shreg       <= '0;
            st_q.pins        <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // configuration readback, straight from flops
    assign cfg_out                      = st_q.cfg;
    // link indicator
    assign link_indicator_pin_level     = st_q.pins.out[0];
    assign link_indicator_pin_oe        = st_q.pins.oe[0];
    // receive indicator
    assign receive_indicator_pin_level  = st_q.pins.out[1];
    assign receive_indicator_pin_oe     = st_q.pins.oe[1];
    // third indicator, no source after reset
    assign third_indicator_pin_level    = st_q.pins.out[2];
    assign third_indicator_pin_oe       = st_q.pins.oe[2];
    // transmit indicator
    assign transmit_indicator_pin_level = st_q.pins.out[3];
    assign transmit_indicator_pin_oe    = st_q.pins.oe[3];
endmodule

// ==== hdl/lsp_pkg.sv ====
package lsp_pkg;

    // ****************************************
    // sizes and counts
    // ****************************************
    localparam int LSP_NUM_LEDS     = 4;
    localparam int LSP_NUM_SRC      = 8;
    localparam int LSP_STRETCH_BITS = 3;
    localparam int LSP_CLK_HZ       = 100_000_000;
    localparam int LSP_TICK_HZ      = 38;
    // stretcher tick period in clock cycles, rounded down
    localparam int LSP_TICK_CYCLES  = LSP_CLK_HZ / LSP_TICK_HZ;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [LSP_NUM_LEDS-1:0] LSP_RST_TOTEM   = 4'h0;
    localparam logic [LSP_NUM_LEDS-1:0] LSP_RST_STRETCH = 4'hF;
    // link on source 0 of led 0, receive source 1 of led 1, transmit source 2 of led 3
    localparam logic [LSP_NUM_SRC-1:0]  LSP_RST_EN0 = 8'h01;
    localparam logic [LSP_NUM_SRC-1:0]  LSP_RST_EN1 = 8'h02;
    localparam logic [LSP_NUM_SRC-1:0]  LSP_RST_EN2 = 8'h00;
    localparam logic [LSP_NUM_SRC-1:0]  LSP_RST_EN3 = 8'h04;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [LSP_NUM_LEDS-1:0][LSP_NUM_SRC-1:0] enable;     // per-led source enables
        logic [LSP_NUM_LEDS-1:0]                  totem;      // 1 totem active high
        logic [LSP_NUM_LEDS-1:0]                  stretch;    // 1 stretcher in path
    } lsp_cfg_t;

    typedef struct packed {
        logic [LSP_NUM_LEDS-1:0] out;  // pin output level
        logic [LSP_NUM_LEDS-1:0] oe;   // pin output enable
    } lsp_pins_t;

endpackage

// ==== hdl/lsp_tick_gen.sv ====
`timescale 1ns/1ps
module lsp_tick_gen #(
    parameter int PERIOD = lsp_pkg::LSP_TICK_CYCLES
) (
    input  wire logic clock,   // device clock
    input  wire logic resetn,  // sync reset, active low
    output logic      tick     // one-cycle pulse per period
);
    import lsp_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } lsp_tick_state_t;

    lsp_tick_state_t st_q;
    lsp_tick_state_t st_d;

    // free-running divider
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == 32'(PERIOD - 1)) begin
            st_d.cnt  = 32'h0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule

// ==== tb/lsp_led_board.sv ====
`timescale 1ns/1ps
// ****************************************
// indicator leds on the board
// ****************************************
module lsp_led_board (
    input  wire logic [3:0] pin_o,  // driven levels
    input  wire logic [3:0] pin_oe, // driver enables
    input  wire logic [3:0] totem,  // how each led is wired
    output logic      [3:0] lit     // led glows
);
    logic [3:0] node;
    // an undriven node floats up to the pull-up, never holds the last level
    assign node = (pin_o & pin_oe) | ~pin_oe;
    // totem leds sink to ground, open-drain leds hang from the supply
    assign lit = (totem & pin_oe & node) | (~totem & ~node);
endmodule

// ==== tb/lsp_led_status_monitor.sv ====
`timescale 1ns/1ps
module lsp_led_status_monitor #(
    parameter int TICK_CYCLES = 10 // stretcher tick period
) (
    input wire logic                            clock,                  // device clock
    input wire logic                            resetn,                 // sync reset
    input wire logic [lsp_pkg::LSP_NUM_SRC-1:0] status_src,             // sources
    input wire logic                            cfg_load,               // config strobe
    input wire lsp_pkg::lsp_cfg_t               cfg_out,                // live config
    input wire logic                            link_indicator_pin_level,   // link_indicator_pin level
    input wire logic                            link_indicator_pin_oe,      // link_indicator_pin enable
    input wire logic                            receive_indicator_pin_level // receive_indicator_pin level
);
    import lsp_pkg::*;
    localparam int FAR = 32'h7FFF_0000;
    int   idle_q;
    logic comb0, comb1;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!resetn);
    // ****************************************
    // link_indicator_pin idle counter, unknown after any load
    // ****************************************
    assign comb0 = |(status_src & cfg_out.enable[0]);
    assign comb1 = |(status_src & cfg_out.enable[1]);
    always_ff @(posedge clock) begin
        if (!resetn || cfg_load) idle_q <= FAR;
        else if (comb0) idle_q <= 0;
        else if (idle_q < FAR) idle_q <= idle_q + 1;
    end
    sequence s_od_str;
        cfg_out.stretch[0] && !cfg_out.totem[0];
    endsequence
    AST_RST_PINS: assert property ($rose(resetn) |-> !link_indicator_pin_oe &&
        !link_indicator_pin_level) else $error("pins lit after reset");
    AST_RST_CFG: assert property ($rose(resetn) |-> cfg_out == {LSP_RST_EN3,
        LSP_RST_EN2, LSP_RST_EN1, LSP_RST_EN0, LSP_RST_TOTEM, LSP_RST_STRETCH})
        else $error("bad reset config");
    AST_TOTEM_OE: assert property (cfg_out.totem[0] && $past(cfg_out.totem[0])
        |-> link_indicator_pin_oe) else $error("totem pin not driven");
    AST_OD_LOW: assert property (!cfg_out.totem[0] && !$past(cfg_out.totem[0])
        |-> !link_indicator_pin_level) else $error("open drain pin driven high");
    AST_SET: assert property ($rose(comb0) ##0 s_od_str |-> ##2 link_indicator_pin_oe)
        else $error("stretcher not set");
    AST_HOLD: assert property (s_od_str ##0 (idle_q inside {[1:2*TICK_CYCLES]})
        |-> link_indicator_pin_oe) else $error("stretch too short");
    AST_CLEAR: assert property (s_od_str ##0 (idle_q inside {[3*TICK_CYCLES+2:FAR-1]})
        |-> !link_indicator_pin_oe) else $error("stretch too long");
    AST_BYPASS: assert property (!cfg_out.stretch[1] && cfg_out.totem[1]
        && $stable(cfg_out) && $stable(status_src)
        |=> receive_indicator_pin_level == $past(comb1))
        else $error("bypass pin wrong");
endmodule

// ==== tb/lsp_led_status_test.sv ====
`timescale 1ns/1ps
module lsp_led_status_test;
    import lsp_pkg::*;
    localparam int TICK = 10;
    logic clock = 0, resetn = 0, cfg_load = 0;
    logic [LSP_NUM_SRC-1:0] status_src = '0;
    lsp_cfg_t   cfg_in = '0, cfg_out, mcfg;
    wire  [3:0] po, poe, lit;
    int err_total = 0, cmp_count = 0, seed = 32'hAAC435B0;
    always #5 clock = ~clock;
    lsp_led_status #(.TICK_CYCLES(TICK)) uut (.clock, .resetn, .status_src, .cfg_load,
        .cfg_in, .cfg_out, .link_indicator_pin_level(po[0]), .link_indicator_pin_oe(poe[0]),
        .receive_indicator_pin_level(po[1]), .receive_indicator_pin_oe(poe[1]),
        .third_indicator_pin_level(po[2]), .third_indicator_pin_oe(poe[2]),
        .transmit_indicator_pin_level(po[3]), .transmit_indicator_pin_oe(poe[3]));
    lsp_led_board board (.pin_o(po), .pin_oe(poe), .totem(mcfg.totem), .lit(lit));
    // ****************************************
    // helpers and model
    // ****************************************
    task automatic check(logic [39:0] seen, logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // glow per led; only_str keeps just the stretched leds
    function automatic logic [3:0] glow(logic [7:0] src, logic only_str);
        for (int i = 0; i < 4; i++)
            glow[i] = |(src & mcfg.enable[i]) & (mcfg.stretch[i] | !only_str);
    endfunction
    task automatic give_verdict;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // even runs pulse the sources one cycle, odd runs hold them
    initial begin
        logic [7:0] s;
        step(16);
        resetn = 1;
        mcfg = {LSP_RST_EN3, LSP_RST_EN2, LSP_RST_EN1, LSP_RST_EN0, LSP_RST_TOTEM,
            LSP_RST_STRETCH};
        check(cfg_out, mcfg);
        check(po | poe, 0);
        for (int it = 0; it < 16; it++) begin
            if (it > 0) begin
                cfg_in = {$random(seed), 8'($random(seed))};
                mcfg = cfg_in;
                cfg_load = 1;
                step(1);
                cfg_load = 0;
                check(cfg_out, mcfg);
            end
            step(40);
            check(lit, 0);
            s = 8'($random(seed));
            status_src = s;
            step(it % 2 ? 5 : 1);
            if (it % 2) check(lit, glow(s, 0));
            status_src = '0;
            step(12);
            check(lit, glow(s, 1));
            step(30);
            check(lit, 0);
        end
        give_verdict();
    end
    // a hang is cut off well past the expected run
    initial begin
        #50_000;
        err_total++;
        give_verdict();
    end
endmodule
bind lsp_led_status lsp_led_status_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.clock,
    .resetn, .status_src, .cfg_load, .cfg_out, .link_indicator_pin_level,
    .link_indicator_pin_oe, .receive_indicator_pin_level);
